/* output_volume_mode_regs.sv */
// output volume, chip mode, frame check and pll divider register group
`timescale 1ns/1ps
module output_volume_mode_regs #(
  parameter int SAMPLE_WIDTH = 16
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic soft_reset,
  input wire logic run_cmd,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic header_load,
  input wire logic [20:0] header_in,
  input wire logic frame_done,
  input wire logic crc_mismatch,
  input wire logic [7:0] pll_fraction_44k_high,
  input wire logic sample_valid,
  input wire logic signed [SAMPLE_WIDTH-1:0] left_in,
  input wire logic signed [SAMPLE_WIDTH-1:0] right_in,
  output logic out_valid,
  output logic signed [SAMPLE_WIDTH-1:0] left_out,
  output logic signed [SAMPLE_WIDTH-1:0] right_out,
  output logic [1:0] emphasis,
  output logic original_stream,
  output logic deemph_none,
  output logic deemph_50_15,
  output logic deemph_j17,
  output logic deemph_reserved,
  output logic session_running,
  output logic [7:0] active_function,
  output logic [7:0] error_code,
  output logic frame_skip,
  output logic crc_mute,
  output logic [5:0] pll_divide_ratio,
  output logic [15:0] pll_fraction_44k
);
  localparam int PW = 2 * SAMPLE_WIDTH + 2;
  localparam logic signed [SAMPLE_WIDTH-1:0] SAT_MAX =
    {1'b0, {(SAMPLE_WIDTH-1){1'b1}}};
  localparam logic signed [SAMPLE_WIDTH-1:0] SAT_MIN =
    {1'b1, {(SAMPLE_WIDTH-1){1'b0}}};

  // register file
  logic [7:0] left_direct_level, next_left_direct_level;
  logic [7:0] left_to_right_crossfeed, next_left_to_right_crossfeed;
  logic [7:0] right_direct_level, next_right_direct_level;
  logic [7:0] right_to_left_crossfeed, next_right_to_left_crossfeed;
  logic [7:0] operating_function_select, next_operating_function_select;
  logic [7:0] frame_check_control, next_frame_check_control;
  logic [7:0] pll_divider_44k, next_pll_divider_44k;
  logic [7:0] pll_fraction_44k_low, next_pll_fraction_44k_low;
  logic [7:0] next_reg_rdata;
  logic [5:0] next_pll_divide_ratio;
  logic [15:0] next_pll_fraction_44k;
  localparam int HEAD_W = output_volume_mode_pkg::HEAD_WIDTH;
  logic [HEAD_W-1:0] head, next_head;

  always_comb begin
    next_left_direct_level = left_direct_level;
    next_left_to_right_crossfeed = left_to_right_crossfeed;
    next_right_direct_level = right_direct_level;
    next_right_to_left_crossfeed = right_to_left_crossfeed;
    next_operating_function_select = operating_function_select;
    next_frame_check_control = frame_check_control;
    next_pll_divider_44k = pll_divider_44k;
    next_pll_fraction_44k_low = pll_fraction_44k_low;
    next_head = head;
    next_reg_rdata = reg_rdata;
    if (header_load) begin
      next_head = header_in;
    end
    if (reg_wr) begin
      unique case (reg_addr)
        output_volume_mode_pkg::ADDR_LEFT_DIRECT:
          next_left_direct_level = reg_wdata;
        output_volume_mode_pkg::ADDR_LEFT_CROSS:
          next_left_to_right_crossfeed = reg_wdata;
        output_volume_mode_pkg::ADDR_RIGHT_DIRECT:
          next_right_direct_level = reg_wdata;
        output_volume_mode_pkg::ADDR_RIGHT_CROSS:
          next_right_to_left_crossfeed = reg_wdata;
        output_volume_mode_pkg::ADDR_FUNC_SELECT:
          next_operating_function_select = reg_wdata;
        output_volume_mode_pkg::ADDR_FRAME_CHECK:
          next_frame_check_control = reg_wdata;
        output_volume_mode_pkg::ADDR_PLL_DIV:
          next_pll_divider_44k = reg_wdata;
        output_volume_mode_pkg::ADDR_PLL_FRAC_LOW:
          next_pll_fraction_44k_low = reg_wdata;
        default: ;
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        output_volume_mode_pkg::ADDR_HEAD_HIGH:
          next_reg_rdata = {3'h0, head[20:16]};
        output_volume_mode_pkg::ADDR_HEAD_MID: next_reg_rdata = head[15:8];
        output_volume_mode_pkg::ADDR_HEAD_LOW: next_reg_rdata = head[7:0];
        output_volume_mode_pkg::ADDR_LEFT_DIRECT:
          next_reg_rdata = left_direct_level;
        output_volume_mode_pkg::ADDR_LEFT_CROSS:
          next_reg_rdata = left_to_right_crossfeed;
        output_volume_mode_pkg::ADDR_RIGHT_DIRECT:
          next_reg_rdata = right_direct_level;
        output_volume_mode_pkg::ADDR_RIGHT_CROSS:
          next_reg_rdata = right_to_left_crossfeed;
        output_volume_mode_pkg::ADDR_FUNC_SELECT:
          next_reg_rdata = operating_function_select;
        output_volume_mode_pkg::ADDR_FRAME_CHECK:
          next_reg_rdata = frame_check_control;
        output_volume_mode_pkg::ADDR_PLL_DIV:
          next_reg_rdata = {3'h0, pll_divider_44k[4:0]};
        output_volume_mode_pkg::ADDR_PLL_FRAC_LOW:
          next_reg_rdata = pll_fraction_44k_low;
        default: next_reg_rdata = output_volume_mode_pkg::READ_UNMAPPED;
      endcase
    end
    // soft reset reloads every writable register except the mode selector
    if (soft_reset) begin
      next_left_direct_level = output_volume_mode_pkg::RST_LEFT_DIRECT;
      next_left_to_right_crossfeed = output_volume_mode_pkg::RST_LEFT_CROSS;
      next_right_direct_level = output_volume_mode_pkg::RST_RIGHT_DIRECT;
      next_right_to_left_crossfeed = output_volume_mode_pkg::RST_RIGHT_CROSS;
      next_frame_check_control = output_volume_mode_pkg::RST_FRAME_CHECK;
      next_pll_divider_44k = output_volume_mode_pkg::RST_PLL_DIV;
      next_pll_fraction_44k_low = output_volume_mode_pkg::RST_PLL_FRAC_LOW;
    end
    next_pll_divide_ratio =
      {1'b0, next_pll_divider_44k[4:0]} + 6'h01;
    next_pll_fraction_44k =
      {pll_fraction_44k_high, next_pll_fraction_44k_low};
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      left_direct_level <= output_volume_mode_pkg::RST_LEFT_DIRECT;
      left_to_right_crossfeed <= output_volume_mode_pkg::RST_LEFT_CROSS;
      right_direct_level <= output_volume_mode_pkg::RST_RIGHT_DIRECT;
      right_to_left_crossfeed <= output_volume_mode_pkg::RST_RIGHT_CROSS;
      operating_function_select <= output_volume_mode_pkg::RST_FUNC_SELECT;
      frame_check_control <= output_volume_mode_pkg::RST_FRAME_CHECK;
      pll_divider_44k <= output_volume_mode_pkg::RST_PLL_DIV;
      pll_fraction_44k_low <= output_volume_mode_pkg::RST_PLL_FRAC_LOW;
      head <= '0;
      reg_rdata <= output_volume_mode_pkg::READ_UNMAPPED;
      pll_divide_ratio <= 6'h01;
      pll_fraction_44k <= 16'h0000;
    end else begin
      left_direct_level <= next_left_direct_level;
      left_to_right_crossfeed <= next_left_to_right_crossfeed;
      right_direct_level <= next_right_direct_level;
      right_to_left_crossfeed <= next_right_to_left_crossfeed;
      operating_function_select <= next_operating_function_select;
      frame_check_control <= next_frame_check_control;
      pll_divider_44k <= next_pll_divider_44k;
      pll_fraction_44k_low <= next_pll_fraction_44k_low;
      head <= next_head;
      reg_rdata <= next_reg_rdata;
      pll_divide_ratio <= next_pll_divide_ratio;
      pll_fraction_44k <= next_pll_fraction_44k;
    end
  end

  // header decode
  logic [1:0] next_emphasis;
  logic next_original_stream;

  always_comb begin
    next_emphasis = next_head[output_volume_mode_pkg::HEAD_EMPH_LSB +: 2];
    next_original_stream =
      next_head[output_volume_mode_pkg::HEAD_ORIGINAL_BIT];
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      emphasis <= output_volume_mode_pkg::EMPH_NONE;
      original_stream <= 1'b0;
      deemph_none <= 1'b1;
      deemph_50_15 <= 1'b0;
      deemph_j17 <= 1'b0;
      deemph_reserved <= 1'b0;
    end else begin
      emphasis <= next_emphasis;
      original_stream <= next_original_stream;
      deemph_none <= next_emphasis == output_volume_mode_pkg::EMPH_NONE;
      deemph_50_15 <= next_emphasis == output_volume_mode_pkg::EMPH_50_15;
      deemph_j17 <= next_emphasis == output_volume_mode_pkg::EMPH_J17;
      deemph_reserved <=
        next_emphasis == output_volume_mode_pkg::EMPH_RESERVED;
    end
  end

  // session: mode captured once per run
  output_volume_mode_pkg::session_t session, next_session;
  logic [7:0] next_active_function;

  always_comb begin
    next_session = session;
    next_active_function = active_function;
    if (soft_reset) begin
      next_session = output_volume_mode_pkg::SESSION_IDLE;
    end else begin
      unique case (session)
        output_volume_mode_pkg::SESSION_IDLE: begin
          if (run_cmd) begin
            next_session = output_volume_mode_pkg::SESSION_RUN;
            next_active_function = operating_function_select;
          end
        end
        output_volume_mode_pkg::SESSION_RUN: ;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      session <= output_volume_mode_pkg::SESSION_IDLE;
      session_running <= 1'b0;
      active_function <= output_volume_mode_pkg::FUNC_AUDIO_DECODE;
    end else begin
      session <= next_session;
      session_running <= next_session == output_volume_mode_pkg::SESSION_RUN;
      active_function <= next_active_function;
    end
  end

  // frame check
  logic check_disabled;
  logic next_frame_skip, next_crc_mute;
  logic [7:0] next_error_code;

  always_comb begin
    check_disabled =
      frame_check_control[output_volume_mode_pkg::FRAME_CHECK_DISABLE_BIT];
    next_frame_skip = 1'b0;
    next_crc_mute = crc_mute;
    next_error_code = error_code;
    if (soft_reset) begin
      next_error_code = output_volume_mode_pkg::ERR_NONE;
      next_crc_mute = 1'b0;
    end
    if (frame_done) begin
      if (crc_mismatch) begin
        next_error_code = output_volume_mode_pkg::ERR_CRC;
        if (!check_disabled) begin
          next_frame_skip = 1'b1;
          next_crc_mute = 1'b1;
        end
      end else if (!soft_reset) begin
        next_crc_mute = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      frame_skip <= 1'b0;
      crc_mute <= 1'b0;
      error_code <= output_volume_mode_pkg::ERR_NONE;
    end else begin
      frame_skip <= next_frame_skip;
      crc_mute <= next_crc_mute;
      error_code <= next_error_code;
    end
  end

  // volume butterfly: gains are left, left to right, right, right to left
  logic [7:0] atten [4];
  logic [15:0] gain [4];

  always_comb begin
    atten[0] = left_direct_level;
    atten[1] = left_to_right_crossfeed;
    atten[2] = right_direct_level;
    atten[3] = right_to_left_crossfeed;
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_gain
      level_gain u_gain (
        .mclk(mclk),
        .reset(reset),
        .atten(atten[gi]),
        .gain(gain[gi])
      );
    end
  endgenerate

  function automatic logic signed [SAMPLE_WIDTH-1:0] mix(
    input logic signed [SAMPLE_WIDTH-1:0] a,
    input logic [15:0] ga,
    input logic signed [SAMPLE_WIDTH-1:0] b,
    input logic [15:0] gb
  );
    logic signed [PW-1:0] sum;
    logic signed [PW-1:0] scaled;
    sum = PW'(a * $signed({1'b0, ga})) + PW'(b * $signed({1'b0, gb}));
    scaled = sum >>> 16;
    if (scaled > PW'(SAT_MAX)) begin
      mix = SAT_MAX;
    end else if (scaled < PW'(SAT_MIN)) begin
      mix = SAT_MIN;
    end else begin
      mix = scaled[SAMPLE_WIDTH-1:0];
    end
  endfunction

  logic next_out_valid;
  logic signed [SAMPLE_WIDTH-1:0] next_left_out, next_right_out;

  always_comb begin
    next_out_valid = sample_valid;
    next_left_out = left_out;
    next_right_out = right_out;
    if (sample_valid) begin
      if (crc_mute) begin
        next_left_out = '0;
        next_right_out = '0;
      end else begin
        next_left_out = mix(left_in, gain[0], right_in, gain[3]);
        next_right_out = mix(right_in, gain[2], left_in, gain[1]);
      end
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      out_valid <= 1'b0;
      left_out <= '0;
      right_out <= '0;
    end else begin
      out_valid <= next_out_valid;
      left_out <= next_left_out;
      right_out <= next_right_out;
    end
  end
endmodule

/* output_volume_mode_pkg.sv */
// constants and types shared by the output volume and mode register group
package output_volume_mode_pkg;
  localparam logic [7:0] ADDR_HEAD_HIGH = 8'h43;
  localparam logic [7:0] ADDR_HEAD_MID = 8'h44;
  localparam logic [7:0] ADDR_HEAD_LOW = 8'h45;
  localparam logic [7:0] ADDR_LEFT_DIRECT = 8'h46;
  localparam logic [7:0] ADDR_LEFT_CROSS = 8'h47;
  localparam logic [7:0] ADDR_RIGHT_DIRECT = 8'h48;
  localparam logic [7:0] ADDR_RIGHT_CROSS = 8'h49;
  localparam logic [7:0] ADDR_FUNC_SELECT = 8'h4D;
  localparam logic [7:0] ADDR_FRAME_CHECK = 8'h4E;
  localparam logic [7:0] ADDR_PLL_DIV = 8'h50;
  localparam logic [7:0] ADDR_PLL_FRAC_LOW = 8'h51;

  localparam logic [7:0] RST_LEFT_DIRECT = 8'h00;
  localparam logic [7:0] RST_LEFT_CROSS = 8'hFF;
  localparam logic [7:0] RST_RIGHT_DIRECT = 8'h00;
  localparam logic [7:0] RST_RIGHT_CROSS = 8'hFF;
  localparam logic [7:0] RST_FUNC_SELECT = 8'h00;
  localparam logic [7:0] RST_FRAME_CHECK = 8'h00;
  localparam logic [7:0] RST_PLL_DIV = 8'h00;
  localparam logic [7:0] RST_PLL_FRAC_LOW = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  localparam int FRAME_CHECK_DISABLE_BIT = 0;
  localparam int PLL_DIV_WIDTH = 5;
  localparam int HEAD_WIDTH = 21;
  localparam int HEAD_EMPH_LSB = 0;
  localparam int HEAD_ORIGINAL_BIT = 2;

  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_CRC = 8'h01;

  localparam logic [1:0] EMPH_NONE = 2'h0;
  localparam logic [1:0] EMPH_50_15 = 2'h1;
  localparam logic [1:0] EMPH_RESERVED = 2'h2;
  localparam logic [1:0] EMPH_J17 = 2'h3;

  // attenuation: 1 dB per unit, codes above the last step are silent
  localparam logic [7:0] ATTEN_LAST_STEP = 8'h60;
  localparam logic [7:0] ATTEN_MAX = 8'hFF;
  // q = code * 171 >> 10 equals code / 6 for all codes up to 96
  localparam logic [7:0] DIV6_MUL = 8'hAB;
  localparam int DIV6_SHIFT = 10;
  localparam logic [2:0] DB_PER_OCTAVE = 3'h6;
  // gain 10^(-k/20) for k = 0..5, unsigned 0.16 fraction
  localparam logic [15:0] GAIN_STEP0 = 16'hFFFF;
  localparam logic [15:0] GAIN_STEP1 = 16'hE429;
  localparam logic [15:0] GAIN_STEP2 = 16'hCB59;
  localparam logic [15:0] GAIN_STEP3 = 16'hB53C;
  localparam logic [15:0] GAIN_STEP4 = 16'hA186;
  localparam logic [15:0] GAIN_STEP5 = 16'h8FF6;

  typedef enum logic [7:0] {
    FUNC_AUDIO_DECODE = 8'h00,
    FUNC_RESERVED = 8'h01,
    FUNC_ADPCM_ENCODE = 8'h02,
    FUNC_ADPCM_DECODE = 8'h03
  } func_t;

  typedef enum logic [0:0] {
    SESSION_IDLE = 1'b0,
    SESSION_RUN = 1'b1
  } session_t;
endpackage

/* level_gain.sv */
// converts an 8-bit attenuation code in dB into a linear gain
`timescale 1ns/1ps
module level_gain (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [7:0] atten,
  output logic [15:0] gain
);
  logic [15:0] next_gain;
  logic [17:0] prod;
  logic [7:0] octave;
  logic [7:0] rem;
  logic [15:0] mant;

  always_comb begin
    prod = 18'(atten) * 18'(output_volume_mode_pkg::DIV6_MUL);
    octave = 8'(prod >> output_volume_mode_pkg::DIV6_SHIFT);
    rem = 8'(atten - 8'(octave * 8'(output_volume_mode_pkg::DB_PER_OCTAVE)));
    unique case (rem)
      8'h00: mant = output_volume_mode_pkg::GAIN_STEP0;
      8'h01: mant = output_volume_mode_pkg::GAIN_STEP1;
      8'h02: mant = output_volume_mode_pkg::GAIN_STEP2;
      8'h03: mant = output_volume_mode_pkg::GAIN_STEP3;
      8'h04: mant = output_volume_mode_pkg::GAIN_STEP4;
      default: mant = output_volume_mode_pkg::GAIN_STEP5;
    endcase
    // each 6 dB halves the gain
    if (atten > output_volume_mode_pkg::ATTEN_LAST_STEP) begin
      next_gain = 16'h0000;
    end else begin
      next_gain = mant >> octave;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      gain <= 16'h0000;
    end else begin
      gain <= next_gain;
    end
  end
endmodule

/* output_volume_mode_regs_props.sv */
// assertions on the ports of the volume and mode register group
`timescale 1ns/1ps
module ovm_props (
  input wire logic mclk,
  input wire logic reset,
  input wire logic soft_reset,
  input wire logic run_cmd,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic header_load,
  input wire logic [20:0] header_in,
  input wire logic frame_done,
  input wire logic crc_mismatch,
  input wire logic [7:0] pll_fraction_44k_high,
  input wire logic [1:0] emphasis,
  input wire logic original_stream,
  input wire logic deemph_50_15,
  input wire logic deemph_j17,
  input wire logic session_running,
  input wire logic [7:0] active_function,
  input wire logic [7:0] error_code,
  input wire logic frame_skip,
  input wire logic crc_mute,
  input wire logic [5:0] pll_divide_ratio,
  input wire logic [15:0] pll_fraction_44k
);
  logic chk_off;
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // mirror of the check disable bit
  always_ff @(posedge mclk or posedge reset) begin
    if (reset)
      chk_off <= 1'b0;
    else if (soft_reset)
      chk_off <= 1'b0;
    else if (reg_wr && reg_addr == 8'h4E)
      chk_off <= reg_wdata[0];
  end
  sequence bad_frame; frame_done && crc_mismatch && !soft_reset; endsequence
  sequence hdr_once; header_load ##1 !header_load; endsequence
  hdr_fields_a: assert property (header_load |=>
    emphasis == $past(header_in[1:0]) && original_stream == $past(header_in[2]))
    else $error("header fields not captured");
  emph_decode_a: assert property (hdr_once |=>
    deemph_j17 == (emphasis == 2'h3) && deemph_50_15 == (emphasis == 2'h1))
    else $error("emphasis decode wrong");
  run_take_a: assert property (
    run_cmd && !session_running && !soft_reset |=> session_running)
    else $error("run command not taken");
  mode_lock_a: assert property (
    session_running && !soft_reset |=> $stable(active_function))
    else $error("active function changed in session");
  crc_on_a: assert property (bad_frame ##0 !chk_off |=>
    frame_skip && crc_mute && error_code == 8'h01)
    else $error("checked mismatch not handled");
  crc_off_a: assert property (bad_frame ##0 chk_off |=>
    !frame_skip && error_code == 8'h01)
    else $error("unchecked mismatch not reported");
  skip_cause_a: assert property (
    frame_skip |-> $past(frame_done && crc_mismatch && !chk_off))
    else $error("frame skipped without cause");
  pll_div_a: assert property (
    reg_wr && reg_addr == 8'h50 && !soft_reset |=>
    pll_divide_ratio == $past(reg_wdata[4:0]) + 6'h01)
    else $error("divide ratio wrong");
  pll_high_a: assert property (1'b1 |=>
    pll_fraction_44k[15:8] == $past(pll_fraction_44k_high))
    else $error("fraction high byte wrong");
endmodule
bind output_volume_mode_regs ovm_props chk (.*);

/* host_model.sv */
// host controller model driving the register bus and session controls
`timescale 1ns/1ps
module host_model (
  input wire logic mclk,
  input wire logic [7:0] reg_rdata,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  output logic reg_rd,
  output logic soft_reset,
  output logic run_cmd
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
    soft_reset = 1'b0;
    run_cmd = 1'b0;
  end
  // released bus shows the inverse of the last value
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~v;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1 v = reg_rdata;
  endtask
  task automatic new_mode(input logic [7:0] m);
    @(posedge mclk);
    soft_reset <= 1'b1;
    @(posedge mclk);
    soft_reset <= 1'b0;
    wr(8'h4D, m);
    @(posedge mclk);
    run_cmd <= 1'b1;
    @(posedge mclk);
    run_cmd <= 1'b0;
  endtask
endmodule

/* tb_top.sv */
// self-checking bench for the volume and mode register group
`timescale 1ns/1ps
module tb_top;
  logic mclk = 1'b0;
  logic reset, soft_reset, run_cmd, reg_wr, reg_rd, header_load;
  logic frame_done, crc_mismatch, sample_valid, out_valid;
  logic original_stream, deemph_none, deemph_50_15, deemph_j17;
  logic deemph_reserved, session_running, frame_skip, crc_mute;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, pll_fraction_44k_high;
  logic [7:0] active_function, error_code, d;
  logic [20:0] header_in, hdr;
  logic signed [15:0] left_in, right_in, left_out, right_out;
  logic [1:0] emphasis;
  logic [5:0] pll_divide_ratio;
  logic [15:0] pll_fraction_44k;
  logic [15:0] steps [6];
  logic [7:0] mdl [256];
  logic [7:0] rw [8];
  bit merr, mute;
  int n_errors = 0;
  int n_compared = 0;
  int unsigned seed;
  always #5 mclk = ~mclk;
  output_volume_mode_regs uut (.*);
  host_model h (.*);
  task automatic chk(input logic [31:0] got, exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t %s got %0h want %0h", $time, what, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("compared %0d mismatched %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic mdl_rst(input bit hard);
    foreach (rw[i])
      if (hard || rw[i] != 8'h4D)
        mdl[rw[i]] = 8'h00;
    mdl[8'h47] = 8'hFF;
    mdl[8'h49] = 8'hFF;
    merr = 1'b0;
    mute = 1'b0;
  endtask
  task automatic w(input logic [7:0] a, v);
    h.wr(a, v);
    foreach (rw[i])
      if (rw[i] == a)
        mdl[a] = v;
  endtask
  function automatic logic [7:0] exp_rd(input logic [7:0] a);
    case (a)
      8'h43: return {3'h0, hdr[20:16]};
      8'h44: return hdr[15:8];
      8'h45: return hdr[7:0];
      8'h50: return mdl[a] & 8'h1F;
      default: return mdl[a];
    endcase
  endfunction
  task automatic rc(input logic [7:0] a);
    h.rd(a, d);
    chk(d, exp_rd(a), "read");
  endtask
  function automatic longint gain(input logic [7:0] c);
    if (c > 8'h60)
      return 0;
    return longint'(steps[c % 6] >> (c / 6));
  endfunction
  function automatic logic [15:0] mix(input int a, input logic [7:0] ga,
      input int b, input logic [7:0] gb);
    longint s;
    s = (a * gain(ga) + b * gain(gb)) >>> 16;
    if (s > 32767)
      s = 32767;
    if (s < -32768)
      s = -32768;
    return 16'(s);
  endfunction
  task automatic frame(input bit b, input bit o);
    w(8'h4E, {7'h00, o});
    @(posedge mclk);
    frame_done <= 1'b1;
    crc_mismatch <= b;
    @(posedge mclk);
    frame_done <= 1'b0;
    crc_mismatch <= ~b;
    #1;
    merr = merr | b;
    mute = b ? (o ? mute : 1'b1) : 1'b0;
    chk({error_code, frame_skip, crc_mute},
      {7'h00, merr, b & ~o, mute}, "frame");
  endtask
  task automatic audio(input logic [7:0] ld, lr, rdl, rl);
    logic signed [15:0] l, r;
    l = 16'($urandom);
    r = 16'($urandom);
    w(8'h46, ld);
    w(8'h47, lr);
    w(8'h48, rdl);
    w(8'h49, rl);
    repeat (2) @(posedge mclk);
    sample_valid <= 1'b1;
    left_in <= l;
    right_in <= r;
    @(posedge mclk);
    sample_valid <= 1'b0;
    left_in <= ~l;
    right_in <= ~r;
    #1;
    chk(out_valid, 1, "valid");
    chk($unsigned(left_out),
      mute ? 16'h0000 : mix(l, ld, r, rl), "left");
    chk($unsigned(right_out),
      mute ? 16'h0000 : mix(r, rdl, l, lr), "right");
  endtask
  initial begin
    seed = $urandom(32'h156BACBE);
    steps = '{output_volume_mode_pkg::GAIN_STEP0,
      output_volume_mode_pkg::GAIN_STEP1,
      output_volume_mode_pkg::GAIN_STEP2,
      output_volume_mode_pkg::GAIN_STEP3,
      output_volume_mode_pkg::GAIN_STEP4,
      output_volume_mode_pkg::GAIN_STEP5};
    rw = '{8'h46, 8'h47, 8'h48, 8'h49, 8'h4D, 8'h4E, 8'h50, 8'h51};
    foreach (mdl[i])
      mdl[i] = 8'h00;
    reset = 1'b1;
    header_load = 1'b0;
    header_in = 21'h000000;
    hdr = 21'h000000;
    frame_done = 1'b0;
    crc_mismatch = 1'b0;
    sample_valid = 1'b0;
    left_in = 16'h0000;
    right_in = 16'h0000;
    pll_fraction_44k_high = 8'($urandom);
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    mdl_rst(1'b1);
    #1;
    chk(pll_divide_ratio, 1, "ratio");
    chk(deemph_none, 1, "none");
    foreach (rw[i])
      rc(rw[i]);
    w(8'h43, 8'h5A);
    w(8'h4A, 8'h5A);
    rc(8'h43);
    rc(8'h4A);
    for (int e = 0; e < 4; e++) begin
      hdr = 21'($urandom);
      hdr[1:0] = e[1:0];
      @(posedge mclk);
      header_load <= 1'b1;
      header_in <= hdr;
      @(posedge mclk);
      header_load <= 1'b0;
      header_in <= ~hdr;
      repeat (2) @(posedge mclk);
      #1;
      chk(emphasis, e, "emph");
      chk(original_stream, hdr[2], "orig");
      chk({deemph_j17, deemph_reserved, deemph_50_15, deemph_none},
        1 << e, "decode");
      for (int a = 8'h43; a < 8'h46; a++)
        rc(8'(a));
    end
    foreach (rw[i])
      w(rw[i], 8'($urandom));
    foreach (rw[i])
      rc(rw[i]);
    chk(pll_divide_ratio, mdl[8'h50][4:0] + 6'h01, "ratio");
    chk(pll_fraction_44k, {pll_fraction_44k_high, mdl[8'h51]}, "frac");
    for (int m = 3; m >= 0; m--) begin
      h.new_mode(8'(m));
      mdl_rst(1'b0);
      mdl[8'h4D] = 8'(m);
      #1;
      chk(active_function, m, "mode");
      w(8'h4D, 8'(3 - m));
      rc(8'h4D);
      chk(active_function, m, "kept");
    end
    foreach (rw[i])
      rc(rw[i]);
    for (int i = 0; i < 8; i++)
      frame(i[0] ^ i[1], i[2]);
    // muted output, and mute kept by an unchecked mismatch
    frame(1'b1, 1'b0);
    frame(1'b1, 1'b1);
    audio(8'h00, 8'h00, 8'h00, 8'h00);
    frame(1'b0, 1'b0);
    audio(8'h00, 8'hFF, 8'h00, 8'hFF);
    audio(8'h06, 8'hFF, 8'h14, 8'hFF);
    audio(8'h60, 8'hFF, 8'hFF, 8'hFF);
    audio(8'hFF, 8'h00, 8'hFF, 8'h00);
    audio(8'h00, 8'h00, 8'h00, 8'h00);
    repeat (4)
      audio(8'($urandom % 97), 8'($urandom % 97),
        8'($urandom % 97), 8'($urandom % 97));
    print_verdict();
  end
  initial begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    $display("MISMATCH %0t run did not finish", $time);
    print_verdict();
  end
endmodule
